// *** smbbs_mem_model.sv ***
// static memory device model shared by both selects
`timescale 1ns/10ps
module smbbs_mem_model (
    input wire logic wide,
    input wire logic [smbbs_pkg::ADDR_W-1:0] bus_address,
    input wire logic [smbbs_pkg::DATA_W-1:0] bus_data_out,
    input wire logic write_strobe_n,
    input wire logic [1:0] byte_select_n,
    input wire logic output_enable_first_n,
    input wire logic output_enable_second_n,
    output logic [smbbs_pkg::DATA_W-1:0] bus_data_in
);
    logic [7:0] mem [0:511];
    logic [8:0] ba;
    logic [15:0] val;
    // wide parts leave the lowest line open
    assign ba = wide ? {bus_address[8:1], 1'b0} : bus_address[8:0];
    assign val = wide ? {mem[ba + 9'h1], mem[ba]} : {8'h00, mem[ba]};
    // released bus shows the inverse so a late sample cannot pass
    assign bus_data_in = (!output_enable_first_n || !output_enable_second_n) ? val : ~val;
    // level write while the strobe is low; byte selects move on the strobe's own edge
    always @* begin
        if (!write_strobe_n && !byte_select_n[0]) mem[ba] = bus_data_out[7:0];
        if (!write_strobe_n && wide && !byte_select_n[1]) mem[ba + 9'h1] = bus_data_out[15:8];
    end
endmodule : smbbs_mem_model

// *** smbbs_pkg.sv ***
// constants and types for the static memory bus boot select block
package smbbs_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // boot region strap codes
    localparam logic [1:0] BOOT_ILLEGAL = 2'h0;
    localparam logic [1:0] BOOT_STACKED = 2'h1;
    localparam logic [1:0] BOOT_SECOND = 2'h2;
    localparam logic [1:0] BOOT_FIRST = 2'h3;
    // first region access: 3..8 with one set-up, or 6..16 with two set-up
    localparam logic [2:0] FIRST_ACC_MIN = 3'h3;
    localparam logic [2:0] FIRST_SETUP_ONE = 3'h1;
    localparam logic [2:0] FIRST_SETUP_TWO = 3'h2;
    // second region access 2,4,8,16,32 cycles as 2 << code
    localparam logic [5:0] SECOND_ACC_BASE = 6'h02;
    localparam logic [5:0] SECOND_SETUP = 6'h01;
    localparam logic [2:0] SECOND_OFF_MIN = 3'h2;
    // reset values: maximum waits, except second data-off code 2 (3 cycles)
    localparam logic [2:0] RST_FIRST_ACC_CODE = 3'h5;
    localparam logic RST_FIRST_DOUBLE = 1'h1;
    localparam logic [1:0] RST_FIRST_OFF_CODE = 2'h3;
    localparam logic [2:0] RST_SECOND_ACC_CODE = 3'h4;
    localparam logic [1:0] RST_SECOND_OFF_CODE = 2'h2;
    localparam logic [1:0] RST_SECOND_ASU_CODE = 2'h3;
    localparam logic [1:0] RST_BOOT_REGION = BOOT_FIRST;
    localparam logic RST_BOOT_WIDTH = 1'h0;
    localparam logic [1:0] BOOT_SETTLE = 2'h3;
    typedef enum logic [2:0] {
        SMBBS_IDLE = 3'b000,
        SMBBS_ASETUP = 3'b001,
        SMBBS_WSETUP = 3'b011,
        SMBBS_STROBE = 3'b010,
        SMBBS_OFF = 3'b110
    } smbbs_state_t;
endpackage : smbbs_pkg

// *** smbbs_properties.sv ***
// pin-level checker for the static memory bus engine
`timescale 1ns/10ps
module smbbs_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] boot_region_strap,
    input wire logic boot_bank_width_strap,
    input wire logic first_wide,
    input wire logic second_wide,
    input wire logic rsp_valid,
    input wire logic [1:0] boot_region,
    input wire logic boot_wide,
    input wire logic boot_done,
    input wire logic boot_strap_illegal,
    input wire logic [smbbs_pkg::ADDR_W-1:0] bus_address,
    input wire logic bus_data_oe,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_first_n,
    input wire logic output_enable_second_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    oe_first_a: assert property (output_enable_first_n == (chip_select_first_n | read_strobe_n))
        else $error("first output enable differs from select and read");
    oe_second_a: assert property (output_enable_second_n == (chip_select_second_n | read_strobe_n))
        else $error("second output enable differs from select and read");
    sel_excl_a: assert property (chip_select_first_n || chip_select_second_n)
        else $error("both selects low");
    drive_dir_a: assert property (!read_strobe_n |-> !bus_data_oe)
        else $error("data driven during read");
    addr_hold_a: assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable(bus_address))
        else $error("address moved under write strobe");
    wide_addr_a: assert property ((!chip_select_first_n && first_wide) || (!chip_select_second_n && second_wide) |-> !bus_address[0])
        else $error("lowest address set on wide bank");
    boot_cap_a: assert property ($rose(boot_done) |-> boot_region == boot_region_strap)
        else $error("boot region not strap value");
    boot_width_a: assert property ($rose(boot_done) |-> boot_wide == boot_bank_width_strap)
        else $error("boot width not strap value");
    illegal_flag_a: assert property (boot_strap_illegal == (boot_region == 2'h0))
        else $error("illegal strap flag wrong");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    strobe_bound_a: assert property ($fell(read_strobe_n) |-> ##[1:40] read_strobe_n)
        else $error("read strobe too long");
    cover property ($rose(boot_done) && boot_strap_illegal);
    cover property ($fell(write_strobe_n) && !chip_select_second_n);
    cover property ($fell(read_strobe_n) && !chip_select_first_n);
    cover property ($fell(read_strobe_n) && $fell(chip_select_first_n));
endmodule : smbbs_properties
bind smbbs_top smbbs_properties u_props (.mclk, .reset, .boot_region_strap, .boot_bank_width_strap,
    .first_wide, .second_wide, .rsp_valid, .boot_region, .boot_wide, .boot_done, .boot_strap_illegal,
    .bus_address, .bus_data_oe, .chip_select_first_n, .chip_select_second_n, .read_strobe_n,
    .write_strobe_n, .output_enable_first_n, .output_enable_second_n);

// *** smbbs_strap.sv ***
// boot strap capture after reset release
`timescale 1ns/10ps
module smbbs_strap (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] boot_region_strap,
    input wire logic boot_bank_width_strap,
    output logic [1:0] boot_region,
    output logic boot_wide,
    output logic boot_done
);
    typedef struct packed {
        logic [1:0] reg_s1;
        logic [1:0] reg_s2;
        logic wid_s1;
        logic wid_s2;
        logic [1:0] settle;
        logic [1:0] region;
        logic wide;
        logic done;
    } smbbs_strap_t;
    smbbs_strap_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.reg_s1 = boot_region_strap;
        s_d.reg_s2 = s_q.reg_s1;
        s_d.wid_s1 = boot_bank_width_strap;
        s_d.wid_s2 = s_q.wid_s1;
        if (!s_q.done) begin
            // wait for the synchroniser to fill before latching
            if (s_q.settle != smbbs_pkg::BOOT_SETTLE) begin
                s_d.settle = s_q.settle + 2'h1;
            end else begin
                s_d.region = s_q.reg_s2;
                s_d.wide = s_q.wid_s2;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.region <= smbbs_pkg::RST_BOOT_REGION;
            s_q.wide <= smbbs_pkg::RST_BOOT_WIDTH;
        end else begin
            s_q <= s_d;
        end
    end

    assign boot_region = s_q.region;
    assign boot_wide = s_q.wide;
    assign boot_done = s_q.done;
endmodule : smbbs_strap

// *** smbbs_top.sv ***
// external static memory bus engine with boot strap selection
`timescale 1ns/10ps
// Summary of operation
// - boot region straps are sampled after reset and reported on boot_region.
// - strap 00 illegal, 01 stacked flash, 10 second select, 11 first select.
// - width strap low gives 8-bit boot bank, high gives 16-bit.
// - first region is one 8 or 16 bit bank, bytes via byte selects.
// - first region serves SRAM, flash and optional page-mode flash.
// - first access 3..8 with one set-up, or 6..16 with two.
// - first region data-off time is 1 to 4 cycles.
// - second region is one 8 or 16 bit bank, bytes via byte selects.
// - second access 2,4,8,16 or 32 cycles including one set-up.
// - second region data-off time is 2, 3 or 4 cycles.
// - second region address set-up is 1 to 4 cycles.
// - write-data set-up zero without write type, else 0 to 3.
// - with write type, write-data set-up equals address set-up minus one.
// - 16-bit devices skip lowest address bit; 8-bit devices use it.
// - each output enable asserts only with its select and read strobe.
module smbbs_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] boot_region_strap,
    input wire logic boot_bank_width_strap,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_region,
    input wire logic [smbbs_pkg::ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_byte_en,
    input wire logic [smbbs_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [smbbs_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic first_wide,
    input wire logic second_wide,
    input wire logic first_page_mode,
    input wire logic first_double_setup,
    input wire logic [2:0] first_access_code,
    input wire logic [1:0] first_off_code,
    input wire logic [2:0] second_access_code,
    input wire logic [1:0] second_off_code,
    input wire logic [1:0] second_addr_setup_code,
    input wire logic write_type_select,
    output logic [1:0] boot_region,
    output logic boot_wide,
    output logic boot_done,
    output logic boot_strap_illegal,
    output logic [smbbs_pkg::ADDR_W-1:0] bus_address,
    output logic [smbbs_pkg::DATA_W-1:0] bus_data_out,
    output logic bus_data_oe,
    input wire logic [smbbs_pkg::DATA_W-1:0] bus_data_in,
    output logic chip_select_first_n,
    output logic chip_select_second_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [1:0] byte_select_n,
    output logic output_enable_first_n,
    output logic output_enable_second_n
);
    typedef struct packed {
        smbbs_pkg::smbbs_state_t st;
        logic [5:0] cnt;
        logic region;
        logic write;
        logic wide;
        logic [smbbs_pkg::ADDR_W-1:0] addr;
        logic [1:0] be;
        logic [smbbs_pkg::DATA_W-1:0] wdata;
        logic [smbbs_pkg::DATA_W-1:0] rdata;
        logic rsp;
        logic cs1_n;
        logic cs2_n;
        logic re_n;
        logic we_n;
        logic oe;
        logic [1:0] bs_n;
        logic [smbbs_pkg::ADDR_W-1:0] page_addr;
        logic page_ok;
        logic [1:0] cap;
    } smbbs_top_t;
    smbbs_top_t s_q, s_d;

    logic [smbbs_pkg::DATA_W-1:0] din_s1_q;
    logic [smbbs_pkg::DATA_W-1:0] din_s2_q;

    // first region strobe cycles = total access minus set-up
    function automatic logic [5:0] first_strobe(input logic dbl, input logic [2:0] code);
        logic [5:0] total;
        logic [5:0] steps;
        // codes past the last step clamp to the longest access
        steps = (code > 3'h5) ? 6'h05 : {3'h0, code};
        // summed at six bits so code 5 cannot wrap
        total = steps + {3'h0, smbbs_pkg::FIRST_ACC_MIN};
        if (dbl) begin
            total = total << 1;
            first_strobe = total - {3'h0, smbbs_pkg::FIRST_SETUP_TWO};
        end else begin
            first_strobe = total - {3'h0, smbbs_pkg::FIRST_SETUP_ONE};
        end
    endfunction : first_strobe

    // device address bit 0 lands on the lowest line for 8-bit, next line for 16-bit
    function automatic logic [smbbs_pkg::ADDR_W-1:0] map_addr(input logic wide,
                                                               input logic [19:0] a);
        map_addr = wide ? {a[19:1], 1'b0} : a;
    endfunction : map_addr

    smbbs_strap u_strap (
        .mclk(mclk),
        .reset(reset),
        .boot_region_strap(boot_region_strap),
        .boot_bank_width_strap(boot_bank_width_strap),
        .boot_region(boot_region),
        .boot_wide(boot_wide),
        .boot_done(boot_done)
    );

    always_comb begin
        logic [2:0] code;
        logic [5:0] strobe_len;
        logic [5:0] asu;
        logic [5:0] wsu;
        logic [5:0] off_len;
        logic wide_sel;
        logic [smbbs_pkg::ADDR_W-1:0] maddr;
        code = 3'h0;
        strobe_len = 6'h00;
        asu = 6'h00;
        wsu = 6'h00;
        off_len = 6'h00;
        wide_sel = 1'b0;
        maddr = '0;
        s_d = s_q;
        s_d.rsp = 1'b0;
        // pin data reaches din_s2_q one edge after the strobe ends
        s_d.cap = {s_q.cap[0], 1'b0};
        if (s_q.cap[1]) begin
            s_d.rsp = 1'b1;
            s_d.rdata = din_s2_q;
        end
        // per-region timing, no ready pin so counts alone close each access
        if (s_q.region) begin
            code = (second_access_code > 3'h4) ? 3'h4 : second_access_code;
            strobe_len = (smbbs_pkg::SECOND_ACC_BASE << code) - smbbs_pkg::SECOND_SETUP;
            asu = {4'h0, second_addr_setup_code} + 6'h01;
            wsu = write_type_select ? asu - 6'h01 : 6'h00;
            off_len = (second_off_code == 2'h0) ? {3'h0, smbbs_pkg::SECOND_OFF_MIN}
                      : {4'h0, second_off_code} + 6'h01;
        end else begin
            strobe_len = first_strobe(first_double_setup, first_access_code);
            asu = first_double_setup ? 6'h02 : 6'h01;
            off_len = {4'h0, first_off_code} + 6'h01;
        end
        // bank width holds the reset boot width (8-bit) until boot settles
        wide_sel = req_region ? second_wide : first_wide;
        if (!boot_done) begin
            wide_sel = boot_wide;
        end
        maddr = map_addr(wide_sel, req_addr);
        case (s_q.st)
            smbbs_pkg::SMBBS_IDLE: begin
                if (req_valid) begin
                    s_d.region = req_region;
                    s_d.write = req_write;
                    s_d.wide = wide_sel;
                    s_d.addr = maddr;
                    s_d.be = wide_sel ? req_byte_en : 2'b01;
                    s_d.wdata = req_wdata;
                    s_d.cs1_n = req_region;
                    s_d.cs2_n = !req_region;
                    // page-mode hit skips set-up on same page reads
                    if (!req_region && first_page_mode && !req_write && s_q.page_ok
                        && (maddr[19:3] == s_q.page_addr[19:3])) begin
                        s_d.st = smbbs_pkg::SMBBS_STROBE;
                        s_d.re_n = 1'b0;
                        s_d.bs_n = ~s_d.be;
                        s_d.cnt = 6'h01;
                    end else begin
                        s_d.st = smbbs_pkg::SMBBS_ASETUP;
                        s_d.cnt = 6'h01;
                    end
                end
            end
            smbbs_pkg::SMBBS_ASETUP: begin
                if (s_q.cnt >= asu - ((s_q.write && s_q.region) ? wsu : 6'h00)) begin
                    s_d.cnt = 6'h01;
                    if (s_q.write) begin
                        s_d.oe = 1'b1;
                    end
                    if (s_q.write && s_q.region && wsu != 6'h00) begin
                        s_d.st = smbbs_pkg::SMBBS_WSETUP;
                    end else begin
                        s_d.st = smbbs_pkg::SMBBS_STROBE;
                        s_d.re_n = s_q.write;
                        s_d.we_n = !s_q.write;
                        s_d.bs_n = ~s_q.be;
                    end
                end else begin
                    s_d.cnt = s_q.cnt + 6'h01;
                end
            end
            smbbs_pkg::SMBBS_WSETUP: begin
                if (s_q.cnt >= wsu) begin
                    s_d.cnt = 6'h01;
                    s_d.st = smbbs_pkg::SMBBS_STROBE;
                    s_d.we_n = 1'b0;
                    s_d.bs_n = ~s_q.be;
                end else begin
                    s_d.cnt = s_q.cnt + 6'h01;
                end
            end
            smbbs_pkg::SMBBS_STROBE: begin
                if (s_q.cnt >= strobe_len) begin
                    s_d.cnt = 6'h01;
                    s_d.st = smbbs_pkg::SMBBS_OFF;
                    s_d.re_n = 1'b1;
                    s_d.we_n = 1'b1;
                    s_d.bs_n = 2'b11;
                    s_d.cap[0] = 1'b1;
                    s_d.page_addr = s_q.addr;
                    // a write leaves the page stale for the next read
                    s_d.page_ok = !s_q.region && !s_q.write;
                end else begin
                    s_d.cnt = s_q.cnt + 6'h01;
                end
            end
            smbbs_pkg::SMBBS_OFF: begin
                s_d.cs1_n = 1'b1;
                s_d.cs2_n = 1'b1;
                if (s_q.cnt >= off_len) begin
                    s_d.oe = 1'b0;
                    s_d.st = smbbs_pkg::SMBBS_IDLE;
                    s_d.cnt = 6'h00;
                end else begin
                    s_d.cnt = s_q.cnt + 6'h01;
                end
            end
            default: begin
                s_d.st = smbbs_pkg::SMBBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.st <= smbbs_pkg::SMBBS_IDLE;
            s_q.cs1_n <= 1'b1;
            s_q.cs2_n <= 1'b1;
            s_q.re_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.bs_n <= 2'b11;
            din_s1_q <= '0;
            din_s2_q <= '0;
        end else begin
            s_q <= s_d;
            din_s1_q <= bus_data_in;
            din_s2_q <= din_s1_q;
        end
    end

    // host side sees read data two clocks after the strobe ends
    assign req_ready = (s_q.st == smbbs_pkg::SMBBS_IDLE);
    assign rsp_valid = s_q.rsp;
    assign rsp_rdata = s_q.rdata;
    assign boot_strap_illegal = boot_done && (boot_region == smbbs_pkg::BOOT_ILLEGAL);
    assign bus_address = s_q.addr;
    assign bus_data_out = s_q.wdata;
    assign bus_data_oe = s_q.oe;
    assign chip_select_first_n = s_q.cs1_n;
    assign chip_select_second_n = s_q.cs2_n;
    assign read_strobe_n = s_q.re_n;
    assign write_strobe_n = s_q.we_n;
    assign byte_select_n = s_q.bs_n;
    assign output_enable_first_n = s_q.cs1_n | s_q.re_n;
    assign output_enable_second_n = s_q.cs2_n | s_q.re_n;
endmodule : smbbs_top

// *** smbbs_top_bench.sv ***
// self-checking bench for the static memory bus engine
`timescale 1ns/10ps
module smbbs_top_bench;
    logic mclk = 0, reset = 1, req_valid = 0, req_write = 0, req_region = 0, first_page_mode = 0;
    logic boot_bank_width_strap = 0, first_wide = 1, second_wide = 1, first_double_setup = 0;
    logic write_type_select = 0, req_ready, rsp_valid, boot_wide, boot_done, boot_strap_illegal;
    logic bus_data_oe, chip_select_first_n, chip_select_second_n, read_strobe_n, write_strobe_n;
    logic output_enable_first_n, output_enable_second_n;
    logic [1:0] boot_region_strap = 2'h3, req_byte_en = 2'h3, first_off_code = 2'h0, boot_region;
    logic [1:0] second_off_code = 2'h0, second_addr_setup_code = 2'h0, byte_select_n;
    logic [2:0] first_access_code = 3'h0, second_access_code = 3'h0;
    logic [smbbs_pkg::ADDR_W-1:0] req_addr = 20'h00010, bus_address;
    logic [smbbs_pkg::DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, bus_data_out, bus_data_in, q;
    int err_total = 0, total_checks = 0, cyc = 0, su, sl, off, dsu;
    always #10 mclk = ~mclk;
    smbbs_top dut (.mclk, .reset, .boot_region_strap, .boot_bank_width_strap, .req_valid,
        .req_write, .req_region, .req_addr, .req_byte_en, .req_wdata, .req_ready, .rsp_valid,
        .rsp_rdata, .first_wide, .second_wide, .first_page_mode, .first_double_setup,
        .first_access_code, .first_off_code, .second_access_code, .second_off_code,
        .second_addr_setup_code, .write_type_select, .boot_region, .boot_wide, .boot_done,
        .boot_strap_illegal, .bus_address, .bus_data_out, .bus_data_oe, .bus_data_in,
        .chip_select_first_n, .chip_select_second_n, .read_strobe_n, .write_strobe_n,
        .byte_select_n, .output_enable_first_n, .output_enable_second_n);
    smbbs_mem_model mem (.wide(chip_select_second_n ? first_wide : second_wide), .bus_address,
        .bus_data_out, .write_strobe_n, .byte_select_n, .output_enable_first_n,
        .output_enable_second_n, .bus_data_in);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    always @(posedge mclk) begin
        cyc++;
        // whole run needs well under ten thousand cycles
        if (cyc == 50000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one access; cycle marks taken at falling edges where pins are settled
    task automatic acc(input logic rg, input logic wr, input logic [15:0] d);
        int c, tc, ts, te, tf, to;
        logic st, cs, got;
        c = 0; tc = -1; ts = -1; te = -1; tf = -1; to = -1;
        got = 0;
        @(negedge mclk);
        req_valid = 1; req_region = rg; req_write = wr; req_wdata = d;
        @(negedge mclk);
        req_valid = 0;
        while (c < 200 && !(c > 2 && req_ready === 1'b1 && tf >= 0 && got)) begin
            st = wr ? write_strobe_n : read_strobe_n;
            cs = rg ? chip_select_second_n : chip_select_first_n;
            if (cs === 1'b0 && tc < 0) tc = c;
            if (bus_data_oe === 1'b1 && to < 0) to = c;
            if (st === 1'b0 && ts < 0) ts = c;
            if (ts >= 0 && st === 1'b1 && te < 0) te = c;
            if (te >= 0 && bus_data_oe !== 1'b1 && tf < 0) tf = c;
            if (rsp_valid === 1'b1) begin
                q = rsp_rdata;
                got = 1;
            end
            @(negedge mclk);
            c++;
        end
        su = ts - tc; sl = te - ts; off = tf - te; dsu = ts - to;
    endtask : acc
    task automatic t_boot();
        int n;
        for (int i = 0; i < 8; i++) begin
            reset = 1; boot_region_strap = i[1:0]; boot_bank_width_strap = i[2];
            repeat (3) @(negedge mclk);
            reset = 0;
            for (n = 0; n < 20 && boot_done !== 1'b1; n++) @(negedge mclk);
            chk(boot_region, i[1:0]);
            chk(boot_wide, i[2]);
            chk(boot_strap_illegal, i[1:0] == 2'h0);
        end
        $display("boot strap test done");
    endtask : t_boot
    task automatic t_first();
        for (int i = 0; i < 12; i++) begin
            first_double_setup = i / 6; first_access_code = i % 6; first_off_code = i % 4;
            acc(0, 1, 16'hA500 + i[15:0]);
            chk(su, i / 6 + 1);
            chk(sl, i < 6 ? i + 2 : 2 * (i - 6 + 3) - 2);
            chk(off, i % 4 + 1);
            acc(0, 0, 16'h0000);
            chk(q, 16'hA500 + i[15:0]);
        end
        $display("first region timing test done");
    endtask : t_first
    task automatic t_second();
        for (int i = 0; i < 5; i++) begin
            second_access_code = i; second_addr_setup_code = i % 4; second_off_code = i % 4;
            acc(1, 1, 16'h5A00 + i[15:0]);
            chk(su, i % 4 + 1);
            chk(sl, (2 << i) - 1);
            chk(off, i % 4 < 2 ? 2 : i % 4 + 1);
            chk(dsu, 0);
            acc(1, 0, 16'h0000);
            chk(q, 16'h5A00 + i[15:0]);
        end
        write_type_select = 1;
        for (int a = 0; a < 4; a++) begin
            second_addr_setup_code = a;
            acc(1, 1, 16'h3C3C);
            chk(dsu, a);
            chk(su, a + 1);
        end
        write_type_select = 0;
        $display("second region timing test done");
    endtask : t_second
    task automatic t_width();
        for (int i = 0; i < 4; i++) begin
            first_wide = i[0]; second_wide = i[0];
            req_addr = 20'h00010;
            acc(i[1], 1, 16'h1234);
            req_addr = i[0] ? 20'h00012 : 20'h00011;
            acc(i[1], 1, 16'hABCD);
            chk(bus_address, i[0] ? 20'h00012 : 20'h00011);
            req_addr = 20'h00010;
            acc(i[1], 0, 16'h0000);
            if (i[0]) chk(q, 16'h1234);
            else chk(q[7:0], 8'h34);
        end
        first_wide = 1; second_wide = 1;
        $display("bank width test done");
    endtask : t_width
    task automatic t_page();
        first_page_mode = 1; first_double_setup = 0;
        req_addr = 20'h00014;
        acc(0, 1, 16'h2468);
        req_addr = 20'h00010;
        acc(0, 0, 16'h0000);
        chk(su, 1);
        req_addr = 20'h00014;
        acc(0, 0, 16'h0000);
        chk(su, 0);
        chk(q, 16'h2468);
        req_byte_en = 2'h2;
        acc(0, 1, 16'hABCD);
        req_byte_en = 2'h3;
        acc(0, 0, 16'h0000);
        chk(q, 16'hAB68);
        first_page_mode = 0; req_addr = 20'h00010;
        $display("page mode test done");
    endtask : t_page
    initial begin
        repeat (3) @(negedge mclk);
        t_boot();
        t_first();
        t_second();
        t_width();
        t_page();
        finish_test();
    end
endmodule : smbbs_top_bench
